// file: hdl/scps_pkg.sv
// shared constants and types for the stop clock power sequencer
package scps_pkg;
  // stop-grant special cycle encoding
  localparam logic [31:0] SCPS_GRANT_ADDR = 32'h0000_0010;
  localparam logic [3:0] SCPS_GRANT_BE_N = 4'hB;
  localparam logic SCPS_GRANT_MIO = 1'h0;
  localparam logic SCPS_GRANT_DC = 1'h0;
  localparam logic SCPS_GRANT_WR = 1'h1;
  // clock rate and wake timing
  localparam int SCPS_CLK_MHZ = 10;
  localparam int SCPS_WAKE_MIN_CLKS = 10;
  localparam int SCPS_WAKE_MAX_CLKS = 20;
  localparam int SCPS_IGNORE_CLKS = 1;
  localparam int SCPS_REARM_CLKS = 5;
  localparam int SCPS_CNT_W = 5;
  localparam logic [SCPS_CNT_W-1:0] SCPS_CNT_ZERO = 5'h00;
  localparam logic [SCPS_CNT_W-1:0] SCPS_CNT_ONE = 5'h01;
  localparam logic [SCPS_CNT_W-1:0] SCPS_WAKE_DONE = SCPS_CNT_W'(SCPS_WAKE_MIN_CLKS);
  localparam logic [SCPS_CNT_W-1:0] SCPS_IGNORE_DONE = SCPS_CNT_W'(SCPS_IGNORE_CLKS);
  // clock-control states, one-hot
  typedef enum logic [6:0] {
    SCPS_NORMAL = 7'h01,
    SCPS_FLUSH_WAIT = 7'h02,
    SCPS_DRAIN = 7'h04,
    SCPS_GRANT_CYC = 7'h08,
    SCPS_STOP_GRANT = 7'h10,
    SCPS_STOP_CLOCK = 7'h20,
    SCPS_WAKE = 7'h40
  } scps_state_type;
  // arbitration winners
  typedef enum logic [2:0] {
    SCPS_EV_NONE = 3'h0,
    SCPS_EV_RESET = 3'h1,
    SCPS_EV_FLUSH = 3'h2,
    SCPS_EV_SMI = 3'h3,
    SCPS_EV_NMI = 3'h4,
    SCPS_EV_MASKABLE_IRQ = 3'h5,
    SCPS_EV_STOP = 3'h6
  } scps_event_type;
endpackage

// file: hdl/scps_sync2.sv
// two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module scps_sync2 #(
  parameter logic RESET_VAL = 1'h0
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r; // first stage, read only by the second
  logic meta_nxt;
  logic sync_r; // second stage
  logic sync_nxt;

  // next values, reset to the idle level
  always_comb
  begin
    meta_nxt = rst_b_in ? async_in : RESET_VAL;
    sync_nxt = rst_b_in ? meta_r : RESET_VAL;
  end

  // register both stages
  always_ff @(posedge mclk_in)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;
endmodule

// file: hdl/scps_sequencer.sv
// stop clock power-down sequencer with external event arbitration
//
// Overview of operation
// - stop halts at next instruction boundary
// - flush, prefetch stop, drain, grant, gate
// - no stop action while bus granted
// - release resumes at following instruction
// - stop never makes acknowledge or vector reads
// - priority reset, flush, smi, nmi, maskable_irq, stop
// - stop request async low, synchronised first
// - stopped input clock gives stop-clock state
// - two phases, phase one at rising edge
// - grant cycle address 10h, enables 1011
// - resume 10 to 20 clocks after release
// - inputs ignored one clock after release
`timescale 1ns/1ps
module scps_sequencer
  import scps_pkg::*;
#(
  parameter int WAKE_CLKS = SCPS_WAKE_MIN_CLKS
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic hard_reset_in, // async pin, active high
  input wire logic soft_reset_in, // async pin, active high
  input wire logic flush_req_n_in, // cache flush request, low
  input wire logic sys_mgmt_irq_n_in, // falling-edge request
  input wire logic nmi_in, // rising-edge request
  input wire logic maskable_irq_in, // level request
  input wire logic stop_request_n_in, // async stop request, low
  input wire logic bus_grant_ack_in, // core is in hold-acknowledge
  input wire logic instr_boundary_in, // core at instruction boundary
  input wire logic flush_busy_in, // cache flush in progress
  input wire logic drain_busy_in, // pipelines or write buffers busy
  input wire logic ready_n_in, // non-burst ready, async pin
  input wire logic burst_ready_n_in, // burst ready, async pin
  input wire logic clk_stopped_in, // input clock monitor: clock halted
  output logic internal_phase_one_out,
  output logic internal_phase_two_out,
  output logic core_clk_en_out, // gates the core clock
  output logic prefetch_stop_out,
  output logic drain_req_out,
  output logic halt_exec_out, // hold core at the boundary
  output logic resume_out, // one-cycle pulse: continue next instruction
  output scps_event_type event_take_out, // winning event at a boundary; reset is reported on any clock
  output logic grant_ads_n_out, // stop-grant cycle strobe
  output logic [31:0] grant_addr_out,
  output logic [3:0] byte_lane_enables_n_out,
  output logic grant_mio_out,
  output logic grant_dc_out,
  output logic grant_wr_out,
  output logic inputs_masked_out, // other inputs not recognised
  output logic in_stop_grant_out,
  output logic in_stop_clock_out
);
  localparam logic [SCPS_CNT_W-1:0] WAKE_DONE = SCPS_CNT_W'(WAKE_CLKS);

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic hrst_s, srst_s, flush_n_s, smi_n_s, nmi_s, maskable_irq_s, stop_n_s, rdy_n_s, burst_ready_n_n_s;
  scps_sync2 #(.RESET_VAL(1'h0)) u_hrst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(hard_reset_in),
    .sync_out(hrst_s));
  scps_sync2 #(.RESET_VAL(1'h0)) u_srst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(soft_reset_in),
    .sync_out(srst_s));
  scps_sync2 #(.RESET_VAL(1'h1)) u_flush (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(flush_req_n_in),
    .sync_out(flush_n_s));
  scps_sync2 #(.RESET_VAL(1'h1)) u_smi (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(sys_mgmt_irq_n_in),
    .sync_out(smi_n_s));
  scps_sync2 #(.RESET_VAL(1'h0)) u_nmi (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(nmi_in),
    .sync_out(nmi_s));
  scps_sync2 #(.RESET_VAL(1'h0)) u_maskable_irq (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(maskable_irq_in),
    .sync_out(maskable_irq_s));
  // stop request synchronised before use
  scps_sync2 #(.RESET_VAL(1'h1)) u_stop (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(stop_request_n_in),
    .sync_out(stop_n_s));
  scps_sync2 #(.RESET_VAL(1'h1)) u_rdy (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(ready_n_in),
    .sync_out(rdy_n_s));
  scps_sync2 #(.RESET_VAL(1'h1)) u_burst_ready_n (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .async_in(burst_ready_n_in),
    .sync_out(burst_ready_n_n_s));

  ////////////////////////////////////////////////////////////////
  // state declarations
  scps_state_type state_r, state_nxt; // clock-control state
  logic [SCPS_CNT_W-1:0] cnt_r, cnt_nxt; // wake and ignore counter
  logic smi_n_d_r, smi_n_d_nxt; // previous smi level for edges
  logic nmi_d_r, nmi_d_nxt; // previous nmi level for edges
  logic smi_pend_r, smi_pend_nxt; // latched smi edge
  logic nmi_pend_r, nmi_pend_nxt; // latched nmi edge
  logic phase_r, phase_nxt; // phase toggle
  logic resume_r, resume_nxt;
  scps_event_type ev_r, ev_nxt;
  scps_event_type win; // combinational winner
  logic masked; // inputs not recognised
  logic acked; // grant cycle acknowledged
  logic any_reset;

  assign any_reset = hrst_s | srst_s;
  assign acked = ~rdy_n_s | ~burst_ready_n_n_s;
  // interrupt pins not seen in stop states or the first clock after release
  assign masked = (state_r == SCPS_STOP_GRANT) | (state_r == SCPS_STOP_CLOCK) |
                  ((state_r == SCPS_WAKE) & (cnt_r < SCPS_IGNORE_DONE));

  ////////////////////////////////////////////////////////////////
  // fixed-priority arbitration, reset highest, stop lowest
  always_comb
  begin
    win = SCPS_EV_NONE;
    if (any_reset)
      win = SCPS_EV_RESET;
    else if (masked)
      win = SCPS_EV_NONE;
    else if (!flush_n_s)
      win = SCPS_EV_FLUSH;
    else if (smi_pend_r)
      win = SCPS_EV_SMI;
    else if (nmi_pend_r)
      win = SCPS_EV_NMI;
    else if (maskable_irq_s)
      win = SCPS_EV_MASKABLE_IRQ;
    else if (!stop_n_s && !bus_grant_ack_in)
      win = SCPS_EV_STOP;
  end

  ////////////////////////////////////////////////////////////////
  // next-state logic for the clock-control sequence
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    resume_nxt = 1'h0;
    ev_nxt = SCPS_EV_NONE;
    smi_n_d_nxt = masked ? smi_n_d_r : smi_n_s;
    nmi_d_nxt = masked ? nmi_d_r : nmi_s;
    // edges latched; set beats consume
    smi_pend_nxt = smi_pend_r;
    nmi_pend_nxt = nmi_pend_r;
    phase_nxt = ~phase_r;
    case (state_r)
      SCPS_NORMAL:
      begin
        if (instr_boundary_in)
        begin
          ev_nxt = win; // stop is reported but never acknowledged on the bus
          if (win == SCPS_EV_SMI)
            smi_pend_nxt = 1'h0;
          if (win == SCPS_EV_NMI)
            nmi_pend_nxt = 1'h0;
          if (win == SCPS_EV_STOP)
            state_nxt = SCPS_FLUSH_WAIT;
        end
      end
      SCPS_FLUSH_WAIT:
      begin
        if (!flush_busy_in)
          state_nxt = SCPS_DRAIN;
      end
      SCPS_DRAIN:
      begin
        if (!drain_busy_in && !bus_grant_ack_in)
          state_nxt = SCPS_GRANT_CYC;
      end
      SCPS_GRANT_CYC:
      begin
        if (acked)
          state_nxt = SCPS_STOP_GRANT;
      end
      SCPS_STOP_GRANT:
      begin
        if (clk_stopped_in)
          state_nxt = SCPS_STOP_CLOCK;
        else if (stop_n_s)
        begin
          state_nxt = SCPS_WAKE;
          cnt_nxt = SCPS_CNT_ZERO;
        end
      end
      SCPS_STOP_CLOCK:
      begin
        if (!clk_stopped_in)
          state_nxt = SCPS_STOP_GRANT;
      end
      SCPS_WAKE:
      begin
        cnt_nxt = cnt_r + SCPS_CNT_ONE;
        if (cnt_r >= WAKE_DONE - SCPS_CNT_ONE)
        begin
          state_nxt = SCPS_NORMAL;
          resume_nxt = 1'h1;
        end
      end
      default:
        state_nxt = SCPS_NORMAL;
    endcase
    if (!masked && smi_n_d_r && !smi_n_s)
      smi_pend_nxt = 1'h1;
    if (!masked && !nmi_d_r && nmi_s)
      nmi_pend_nxt = 1'h1;
    // reset or soft reset leaves any low-power state
    if (any_reset)
    begin
      state_nxt = SCPS_NORMAL;
      ev_nxt = SCPS_EV_RESET;
      smi_pend_nxt = 1'h0;
      nmi_pend_nxt = 1'h0;
    end
    if (!rst_b_in)
    begin
      state_nxt = SCPS_NORMAL;
      cnt_nxt = SCPS_CNT_ZERO;
      resume_nxt = 1'h0;
      ev_nxt = SCPS_EV_NONE;
      smi_n_d_nxt = 1'h1;
      nmi_d_nxt = 1'h0;
      smi_pend_nxt = 1'h0;
      nmi_pend_nxt = 1'h0;
      phase_nxt = 1'h0;
    end
  end

  // register the sequence state
  always_ff @(posedge mclk_in)
  begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    resume_r <= resume_nxt;
    ev_r <= ev_nxt;
    smi_n_d_r <= smi_n_d_nxt;
    nmi_d_r <= nmi_d_nxt;
    smi_pend_r <= smi_pend_nxt;
    nmi_pend_r <= nmi_pend_nxt;
    phase_r <= phase_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // outputs decoded from state registers
  assign internal_phase_one_out = ~phase_r;
  assign internal_phase_two_out = phase_r;
  assign prefetch_stop_out = (state_r != SCPS_NORMAL);
  assign drain_req_out = (state_r == SCPS_DRAIN);
  assign halt_exec_out = (state_r != SCPS_NORMAL);
  assign core_clk_en_out = ~((state_r == SCPS_STOP_GRANT) | (state_r == SCPS_STOP_CLOCK));
  assign resume_out = resume_r;
  assign event_take_out = ev_r;
  // grant cycle drive; constant encoding
  assign grant_ads_n_out = ~(state_r == SCPS_GRANT_CYC);
  assign grant_addr_out = SCPS_GRANT_ADDR;
  assign byte_lane_enables_n_out = SCPS_GRANT_BE_N;
  assign grant_mio_out = SCPS_GRANT_MIO;
  assign grant_dc_out = SCPS_GRANT_DC;
  assign grant_wr_out = SCPS_GRANT_WR;
  assign inputs_masked_out = masked;
  assign in_stop_grant_out = (state_r == SCPS_STOP_GRANT);
  assign in_stop_clock_out = (state_r == SCPS_STOP_CLOCK);
endmodule

// file: dv/scps_checker.sv
// assertion checker for the stop clock power sequencer
`timescale 1ns/1ps
module scps_checker
  import scps_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic stop_request_n_in,
  input wire logic bus_grant_ack_in,
  input wire logic instr_boundary_in,
  input wire logic clk_stopped_in,
  input wire logic internal_phase_one_out,
  input wire logic internal_phase_two_out,
  input wire logic core_clk_en_out,
  input wire logic resume_out,
  input wire scps_event_type event_take_out,
  input wire logic grant_ads_n_out,
  input wire logic [31:0] grant_addr_out,
  input wire logic [3:0] byte_lane_enables_n_out,
  input wire logic grant_mio_out,
  input wire logic grant_dc_out,
  input wire logic grant_wr_out,
  input wire logic in_stop_grant_out,
  input wire logic in_stop_clock_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  //////////////////////////////////////////////////
  // wake: quiet for eight clocks, then one resume pulse
  sequence s_quiet; !resume_out [*8]; endsequence
  sequence s_wake; s_quiet ##[2:12] resume_out; endsequence
  property p_wake; $rose(stop_request_n_in) && in_stop_grant_out |-> s_wake; endproperty
  a_wake: assert property (p_wake)
    else $error("resume pulse outside wake window");
  // synchroniser delay before a stop can win
  property p_sync; $fell(stop_request_n_in) |=> event_take_out != SCPS_EV_STOP; endproperty
  a_sync: assert property (p_sync)
    else $error("stop taken without synchroniser delay");
  property p_boundary; event_take_out == SCPS_EV_STOP |-> $past(instr_boundary_in); endproperty
  a_boundary: assert property (p_boundary)
    else $error("stop taken off an instruction boundary");
  property p_hold; bus_grant_ack_in |=> event_take_out != SCPS_EV_STOP; endproperty
  a_hold: assert property (p_hold)
    else $error("stop taken while bus granted");
  property p_enter; $rose(in_stop_grant_out) && !$past(in_stop_clock_out) |-> $past(grant_ads_n_out) == 1'h0;
  endproperty
  a_enter: assert property (p_enter)
    else $error("stop grant entered without grant cycle");
  property p_gate; in_stop_grant_out || in_stop_clock_out |-> !core_clk_en_out; endproperty
  a_gate: assert property (p_gate)
    else $error("core clock running in a stop state");
  property p_cycle; !grant_ads_n_out |-> grant_addr_out == SCPS_GRANT_ADDR
    && byte_lane_enables_n_out == SCPS_GRANT_BE_N && grant_mio_out == SCPS_GRANT_MIO
    && grant_dc_out == SCPS_GRANT_DC && grant_wr_out == SCPS_GRANT_WR; endproperty
  a_cycle: assert property (p_cycle)
    else $error("grant cycle encoding wrong");
  property p_clkstop; in_stop_grant_out && clk_stopped_in |=> in_stop_clock_out; endproperty
  a_clkstop: assert property (p_clkstop)
    else $error("halted clock did not give stop clock state");
  property p_phase; internal_phase_one_out |=> !internal_phase_one_out && internal_phase_two_out; endproperty
  a_phase: assert property (p_phase)
    else $error("internal phases not alternating");
endmodule
bind scps_sequencer scps_checker chk (.*);

// file: dv/scps_sys_model.sv
// system side model: stop request driver and ready responder
`timescale 1ns/1ps
module scps_sys_model #(
  parameter int READY_DLY = 1
) (
  input wire logic mclk_in,
  input wire logic want_stop_in, // bench wants the core stopped
  input wire logic grant_ads_n_in,
  output logic stop_request_n_out,
  output logic ready_n_out
);
  logic acked_r; // grant cycle answered
  int wait_r; // clocks the grant strobe has been low
  int gap_r; // clocks the request has been high
  initial
  begin
    stop_request_n_out = 1'h1;
    ready_n_out = 1'h1;
    acked_r = 1'h0;
    wait_r = 0;
    gap_r = 9;
  end
  //////////////////////////////////////////////////
  // answer the grant cycle, then release only after the answer
  always @(posedge mclk_in)
  begin
    wait_r <= grant_ads_n_in ? 0 : wait_r + 1;
    ready_n_out <= !(!grant_ads_n_in && wait_r >= READY_DLY);
    if (!ready_n_out && !stop_request_n_out)
      acked_r <= 1'h1;
    gap_r <= stop_request_n_out ? gap_r + 1 : 0;
    if (want_stop_in && stop_request_n_out && gap_r >= 5)
      stop_request_n_out <= 1'h0;
    else if (!want_stop_in && acked_r)
    begin
      stop_request_n_out <= 1'h1;
      acked_r <= 1'h0;
    end
  end
endmodule

// file: dv/stop_clock_power_sequencer_tb.sv
// self-checking bench for the stop clock power sequencer
`timescale 1ns/1ps
module stop_clock_power_sequencer_tb;
  import scps_pkg::*;
  logic mclk_in, rst_b_in, hard_reset_in, soft_reset_in, flush_req_n_in, sys_mgmt_irq_n_in, nmi_in;
  logic maskable_irq_in, stop_request_n_in, bus_grant_ack_in, instr_boundary_in, flush_busy_in;
  logic drain_busy_in, ready_n_in, burst_ready_n_in, clk_stopped_in, want_stop;
  logic internal_phase_one_out, internal_phase_two_out, core_clk_en_out, prefetch_stop_out;
  logic drain_req_out, halt_exec_out, resume_out, grant_ads_n_out, grant_mio_out, grant_dc_out;
  logic grant_wr_out, inputs_masked_out, in_stop_grant_out, in_stop_clock_out;
  logic [31:0] grant_addr_out;
  logic [3:0] byte_lane_enables_n_out;
  scps_event_type event_take_out, last_ev;
  int err_count, total_checks, cyc;
  scps_sequencer dut (.*);
  scps_sys_model #(.READY_DLY(2)) sys (.mclk_in(mclk_in), .want_stop_in(want_stop),
    .grant_ads_n_in(grant_ads_n_out), .stop_request_n_out(stop_request_n_in), .ready_n_out(ready_n_in));
  //////////////////////////////////////////////////
  // clock, winner capture and hang limit
  initial
  begin
    mclk_in = 1'h0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    if (event_take_out != SCPS_EV_NONE)
      last_ev <= event_take_out;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // wait for grant strobe (0), stop grant (1) or resume pulse (2)
  task automatic wait_on(input int which, output int n);
    for (n = 0; n < 60; n++)
    begin
      @(posedge mclk_in);
      #1;
      if (which == 0 ? grant_ads_n_out === 1'h0 : which == 1 ? in_stop_grant_out === 1'h1 : resume_out === 1'h1)
        break;
    end
    check(n < 60, 32'h1);
  endtask
  // grant cycle, stop grant, stop clock, release and wake
  task automatic finish_stop();
    int n;
    wait_on(0, n);
    check(grant_addr_out, SCPS_GRANT_ADDR);
    check({grant_mio_out, grant_dc_out, grant_wr_out, byte_lane_enables_n_out}, 32'h1B);
    wait_on(1, n);
    check(core_clk_en_out, 32'h0);
    check(inputs_masked_out, 32'h1);
    @(posedge mclk_in) clk_stopped_in <= 1'h1;
    clk(2);
    #1 check(in_stop_clock_out, 32'h1);
    @(posedge mclk_in) clk_stopped_in <= 1'h0;
    want_stop <= 1'h0;
    wait_on(2, n);
    check(n >= SCPS_WAKE_MIN_CLKS && n <= SCPS_WAKE_MAX_CLKS, 32'h1);
    clk(1);
    #1 check({halt_exec_out, core_clk_en_out}, 32'h1);
    clk(8);
  endtask
  task automatic t_full();
    @(posedge mclk_in) flush_busy_in <= 1'h1;
    drain_busy_in <= 1'h1;
    want_stop <= 1'h1;
    clk(8);
    #1 check({prefetch_stop_out, drain_req_out}, 32'h2);
    check(last_ev, SCPS_EV_STOP);
    @(posedge mclk_in) flush_busy_in <= 1'h0;
    clk(3);
    #1 check({drain_req_out, grant_ads_n_out}, 32'h3);
    @(posedge mclk_in) drain_busy_in <= 1'h0;
    finish_stop();
    $display("test full sequence done");
  endtask
  task automatic t_hold();
    bus_grant_ack_in <= 1'h1;
    want_stop <= 1'h1;
    clk(10);
    #1 check({prefetch_stop_out, grant_ads_n_out}, 32'h1);
    @(posedge mclk_in) bus_grant_ack_in <= 1'h0;
    finish_stop();
    $display("test bus hold done");
  endtask
  task automatic t_prio();
    instr_boundary_in <= 1'h0;
    hard_reset_in <= 1'h1;
    soft_reset_in <= 1'h1;
    flush_req_n_in <= 1'h0;
    maskable_irq_in <= 1'h1;
    want_stop <= 1'h1;
    clk(6);
    for (int i = 1; i <= 6; i++)
    begin
      @(posedge mclk_in) instr_boundary_in <= 1'h1;
      @(posedge mclk_in) instr_boundary_in <= 1'h0;
      clk(2);
      #1 check(last_ev, i);
      @(posedge mclk_in);
      case (i)
        1: {hard_reset_in, soft_reset_in, sys_mgmt_irq_n_in, nmi_in} <= 4'h1;
        2: flush_req_n_in <= 1'h1;
        4: nmi_in <= 1'h0;
        5: maskable_irq_in <= 1'h0;
        default: ;
      endcase
      // last pass goes straight on to catch the grant strobe
      if (i < 6)
        clk(4);
    end
    finish_stop();
    $display("test priority done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {err_count, total_checks, cyc} = '0;
    rst_b_in <= 1'h0;
    {hard_reset_in, soft_reset_in, nmi_in, maskable_irq_in, bus_grant_ack_in} <= 5'h0;
    {flush_busy_in, drain_busy_in, clk_stopped_in, want_stop} <= 4'h0;
    {flush_req_n_in, sys_mgmt_irq_n_in, burst_ready_n_in, instr_boundary_in} <= 4'hF;
    clk(5);
    rst_b_in <= 1'h1;
    clk(3);
    #1 check({core_clk_en_out, grant_ads_n_out, halt_exec_out, in_stop_grant_out}, 32'hC);
    t_full();
    t_hold();
    t_prio();
    complete_run();
  end
endmodule
